// ### verilog/sac_cache_map.vh
// Constant map for the set-associative cache with debug index access
`ifndef SAC_CACHE_MAP_VH
`define SAC_CACHE_MAP_VH

// ----------------------------------------------------------------
// Address split
// ----------------------------------------------------------------
`define SAC_BYTE_LSB        0
`define SAC_WORD_LSB        2
`define SAC_WORD_MSB        4
`define SAC_INDEX_LSB       5
`define SAC_ADDR_MSB        31

// ----------------------------------------------------------------
// Debug index register layout and reset
// ----------------------------------------------------------------
`define SAC_DBG_WAY_MSB     31
`define SAC_DBG_WAY_LSB     30
`define SAC_DBG_RESET       32'h00000000

// ----------------------------------------------------------------
// Tag transfer word layout (tag bits above index, status below)
// ----------------------------------------------------------------
`define SAC_TW_VALID        4
`define SAC_TW_DIRTY_HI     3
`define SAC_TW_DIRTY_LO     2

// ----------------------------------------------------------------
// Debug operation codes
// ----------------------------------------------------------------
`define SAC_OP_IDX_WR       3'h1
`define SAC_OP_IDX_RD       3'h2
`define SAC_OP_TAG_WR       3'h3
`define SAC_OP_TAG_RD       3'h4
`define SAC_OP_DAT_WR       3'h5
`define SAC_OP_DAT_RD       3'h6

// ----------------------------------------------------------------
// Replacement modes
// ----------------------------------------------------------------
`define SAC_REPL_RANDOM     1'b0
`define SAC_REPL_ROUND      1'b1
`define SAC_LFSR_SEED       8'hA5

`endif

// ### verilog/sac_victim_ctr.v
// Victim way segment counter with lockdown floor for the cache
`timescale 1ns/1ps
module sac_victim_ctr (
  // Clock and reset
  input  wire       clk,
  input  wire       nrst,
  // Control
  input  wire       advance,   // One pulse per allocation
  input  wire       repl_mode, // Round robin or pseudo random
  input  wire [1:0] lock_base, // Lowest way that may be replaced
  // Result
  output reg  [1:0] victim
);

`include "sac_cache_map.vh"

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0] lfsr;      // Pseudo random source
  wire [1:0] span;      // Number of replaceable ways minus one
  wire [1:0] rnd_pick;  // Random way inside the span
  wire [1:0] next_rr;   // Next round robin way

  assign span     = 2'h3 - lock_base;
  // Mask random bits into the open span; span+1 ways, all powers of two but 3
  assign rnd_pick = lock_base + ((span == 2'h2) ? {1'b0, lfsr[0]} : (lfsr[1:0] & span));
  assign next_rr  = (victim == 2'h3 || victim < lock_base) ? lock_base : victim + 2'h1;

  // LFSR runs every cycle so the pick is decoupled from access pattern
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lfsr <= `SAC_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // Counter only moves inside the unlocked range
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      victim <= 2'h0;
    end else if (advance) begin
      if (repl_mode == `SAC_REPL_ROUND) begin
        victim <= next_rr;
      end else begin
        victim <= rnd_pick;
      end
    end else if (victim < lock_base) begin
      victim <= lock_base; // Lock raised: leave the locked ways at once
    end
  end

endmodule

// ### verilog/sac_cache.v
// Four-way set-associative cache with debug index register access
// Behaviour
// - Debug index field starts bit 5
// - Tag operations ignore word position field
// - Index/tag split follows configured size
// - Size configurable zero or 4KB..1MB
// - Four ways, eight-word 32-byte lines
// - Read hit answers in one cycle
// - Each way has tag and data memory
// - Compare all tags, return matching way
// - Miss goes external; buffered writes buffered
// - Cachable read miss allocates; writes do not
// - Segment counter picks victim, two modes
// - Lockdown keeps counter off locked ways
// - Whole flush clears locked lines too
// - Address splits byte, word, index, tag
// - Valid bit gates hits, reset clears
// - Two dirty bits per data entry
// - Dirty set only in write-back regions
`timescale 1ns/1ps
module sac_cache #(
  parameter SIZE_LOG2 = 12, // Capacity as log2 bytes, 12..20
  parameter PRESENT   = 1,  // Zero selects a cache of 0KB
  parameter IS_DATA   = 1   // Data cache keeps dirty bits
) (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Core access
  input  wire        acc_req,       // Access request, one cycle
  input  wire        acc_write,     // Store when high
  input  wire [31:0] acc_addr,
  input  wire [31:0] acc_wdata,
  input  wire        acc_cachable,  // Region cachable
  input  wire        acc_bufferable,// Region bufferable
  output reg         acc_hit,       // Pulse: read hit data valid
  output reg  [31:0] acc_rdata,
  // External side
  output reg         ext_req,       // Pulse: uncached or fill access
  output reg         ext_wbuf,      // Pulse: store to write buffer
  output reg  [31:0] ext_addr,
  output reg  [31:0] ext_wdata,
  input  wire        fill_valid,    // Fill word strobe
  input  wire [31:0] fill_data,
  output reg         fill_busy,     // Line fill in progress
  // Control
  input  wire        repl_mode,
  input  wire [1:0]  lock_base,
  input  wire        flush_all,     // Pulse
  input  wire        flush_line,    // Pulse, address on acc_addr
  // Debug operations
  input  wire        dbg_req,
  input  wire [2:0]  dbg_op,
  input  wire [31:0] dbg_wdata,
  output reg         dbg_ack,
  output reg  [31:0] dbg_rdata
);

`include "sac_cache_map.vh"

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam WAYS   = 4;
  localparam IDX_W  = SIZE_LOG2 - 7;       // 4 ways x 32-byte lines
  localparam SETS   = 1 << IDX_W;
  localparam IDX_M  = `SAC_INDEX_LSB + IDX_W - 1;
  localparam TAG_W  = `SAC_ADDR_MSB - IDX_M;
  localparam WORDS  = 8;

  localparam ST_IDLE = 1'b0;
  localparam ST_FILL = 1'b1;

  // ----------------------------------------------------------------
  // Storage, separate tag and data arrays per way
  // ----------------------------------------------------------------
  reg [TAG_W-1:0] tag_mem  [0:WAYS*SETS-1];
  reg [31:0]      data_mem [0:WAYS*SETS*WORDS-1];
  reg [WAYS*SETS-1:0] valid;
  reg [WAYS*SETS-1:0] dirty_lo;
  reg [WAYS*SETS-1:0] dirty_hi;

  reg [31:0]  dbg_index;   // Debug index register
  reg         state;       // Fill engine state
  reg [2:0]   fill_cnt;    // Fill word position
  reg [31:0]  fill_addr;   // Line being filled
  reg [1:0]   fill_way;    // Way receiving the fill
  reg         vic_adv;     // Advance segment counter
  wire [1:0]  victim;
  integer     w;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  // Line index of an address
  function [IDX_W-1:0] f_index;
    input [31:0] a;
    begin
      f_index = a[IDX_M:`SAC_INDEX_LSB];
    end
  endfunction

  // Tag of an address
  function [TAG_W-1:0] f_tag;
    input [31:0] a;
    begin
      f_tag = a[`SAC_ADDR_MSB:IDX_M+1];
    end
  endfunction

  // Flat entry number of a way and set
  function [IDX_W+1:0] f_ent;
    input [1:0] way;
    input [IDX_W-1:0] idx;
    begin
      f_ent = {way, idx};
    end
  endfunction

  // ----------------------------------------------------------------
  // Lookup across all four ways
  // ----------------------------------------------------------------
  reg        hit;
  reg [1:0]  hit_way;
  wire [IDX_W-1:0] a_idx  = f_index(acc_addr);
  wire [TAG_W-1:0] a_tag  = f_tag(acc_addr);
  wire [2:0]       a_word = acc_addr[`SAC_WORD_MSB:`SAC_WORD_LSB];

  // Compare every tag; only valid entries may hit
  always @* begin
    hit     = 1'b0;
    hit_way = 2'h0;
    for (w = 0; w < WAYS; w = w + 1) begin
      if (PRESENT != 0 && valid[f_ent(w[1:0], a_idx)] &&
          tag_mem[f_ent(w[1:0], a_idx)] == a_tag) begin
        hit     = 1'b1;
        hit_way = w[1:0];
      end
    end
  end

  // Debug index decode: way in top bits, index from bit 5
  wire [1:0]       d_way  = dbg_index[`SAC_DBG_WAY_MSB:`SAC_DBG_WAY_LSB];
  wire [IDX_W-1:0] d_idx  = f_index(dbg_index);
  wire [2:0]       d_word = dbg_index[`SAC_WORD_MSB:`SAC_WORD_LSB];
  wire [IDX_W+1:0] d_ent  = f_ent(d_way, d_idx); // Word field unused here
  wire             d_wb   = (IS_DATA != 0);

  // ----------------------------------------------------------------
  // Segment counter
  // ----------------------------------------------------------------
  sac_victim_ctr u_victim (
    .clk       (clk),
    .nrst      (nrst),
    .advance   (vic_adv),
    .repl_mode (repl_mode),
    .lock_base (lock_base),
    .victim    (victim)
  );

  // ----------------------------------------------------------------
  // Array writes: fills, store hits, debug writes
  // ----------------------------------------------------------------
  // Arrays have no reset; only valid and dirty bits carry control state
  always @(posedge clk) begin
    if (state == ST_FILL && fill_valid) begin
      data_mem[{f_ent(fill_way, f_index(fill_addr)), fill_cnt}] <= fill_data;
      if (fill_cnt == 3'h0) begin
        tag_mem[f_ent(fill_way, f_index(fill_addr))] <= f_tag(fill_addr);
      end
    end else if (state == ST_IDLE && acc_req && acc_write && hit) begin
      data_mem[{f_ent(hit_way, a_idx), a_word}] <= acc_wdata;
    end else if (dbg_req && dbg_op == `SAC_OP_TAG_WR) begin
      tag_mem[d_ent] <= f_tag(dbg_wdata); // Tag bits only
    end else if (dbg_req && dbg_op == `SAC_OP_DAT_WR) begin
      data_mem[{d_ent, d_word}] <= dbg_wdata; // Software set index first
    end
  end

  // ----------------------------------------------------------------
  // Valid and dirty status
  // ----------------------------------------------------------------
  // Whole flush clears everything, locked ways included
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid    <= {WAYS*SETS{1'b0}};
      dirty_lo <= {WAYS*SETS{1'b0}};
      dirty_hi <= {WAYS*SETS{1'b0}};
    end else if (flush_all) begin
      valid    <= {WAYS*SETS{1'b0}};
      dirty_lo <= {WAYS*SETS{1'b0}};
      dirty_hi <= {WAYS*SETS{1'b0}};
    end else if (flush_line && hit) begin
      valid[f_ent(hit_way, a_idx)] <= 1'b0;
    end else if (state == ST_FILL && fill_valid) begin
      if (fill_cnt == 3'h0) begin
        valid[f_ent(fill_way, f_index(fill_addr))]    <= 1'b0; // Hide partial line
        dirty_lo[f_ent(fill_way, f_index(fill_addr))] <= 1'b0;
        dirty_hi[f_ent(fill_way, f_index(fill_addr))] <= 1'b0;
      end else if (fill_cnt == 3'h7) begin
        valid[f_ent(fill_way, f_index(fill_addr))] <= 1'b1;
      end
    end else if (state == ST_IDLE && acc_req && acc_write && hit) begin
      // Write-back region only; write-through never dirties
      if (d_wb && acc_cachable && acc_bufferable) begin
        if (a_word[2]) begin
          dirty_hi[f_ent(hit_way, a_idx)] <= 1'b1;
        end else begin
          dirty_lo[f_ent(hit_way, a_idx)] <= 1'b1;
        end
      end
    end else if (dbg_req && dbg_op == `SAC_OP_TAG_WR) begin
      valid[d_ent]    <= dbg_wdata[`SAC_TW_VALID];
      dirty_hi[d_ent] <= d_wb & dbg_wdata[`SAC_TW_DIRTY_HI];
      dirty_lo[d_ent] <= d_wb & dbg_wdata[`SAC_TW_DIRTY_LO];
    end
  end

  // ----------------------------------------------------------------
  // Debug index register and debug reads
  // ----------------------------------------------------------------
  // Reserved bits stored as zero so they read back as zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dbg_index <= `SAC_DBG_RESET;
      dbg_ack   <= 1'b0;
      dbg_rdata <= 32'h00000000;
    end else begin
      dbg_ack <= dbg_req;
      if (dbg_req) begin
        case (dbg_op)
          `SAC_OP_IDX_WR: begin
            dbg_index <= {dbg_wdata[`SAC_DBG_WAY_MSB:`SAC_DBG_WAY_LSB],
                          {(`SAC_DBG_WAY_LSB-IDX_M-1){1'b0}},
                          dbg_wdata[IDX_M:`SAC_WORD_LSB], 2'h0};
          end
          `SAC_OP_IDX_RD: begin
            dbg_rdata <= dbg_index;
          end
          `SAC_OP_TAG_RD: begin
            // Word field ignored for tag reads
            dbg_rdata <= {tag_mem[d_ent], {(IDX_M-`SAC_TW_VALID){1'b0}},
                          valid[d_ent], dirty_hi[d_ent], dirty_lo[d_ent], 2'h0};
          end
          `SAC_OP_DAT_RD: begin
            dbg_rdata <= data_mem[{d_ent, d_word}];
          end
          default: begin
            dbg_rdata <= dbg_rdata;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Core answer, miss routing and fill engine
  // ----------------------------------------------------------------
  // Hit answers at the next edge, no wait state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_hit   <= 1'b0;
      acc_rdata <= 32'h00000000;
      ext_req   <= 1'b0;
      ext_wbuf  <= 1'b0;
      ext_addr  <= 32'h00000000;
      ext_wdata <= 32'h00000000;
      fill_busy <= 1'b0;
      state     <= ST_IDLE;
      fill_cnt  <= 3'h0;
      fill_addr <= 32'h00000000;
      fill_way  <= 2'h0;
      vic_adv   <= 1'b0;
    end else begin
      acc_hit  <= 1'b0;
      ext_req  <= 1'b0;
      ext_wbuf <= 1'b0;
      vic_adv  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (acc_req && !acc_write && hit && acc_cachable) begin
            acc_hit   <= 1'b1;
            acc_rdata <= data_mem[{f_ent(hit_way, a_idx), a_word}];
          end else if (acc_req && acc_write) begin
            // Write misses never allocate
            if (!hit || !(acc_cachable && acc_bufferable)) begin
              ext_wdata <= acc_wdata;
              ext_addr  <= acc_addr;
              if (acc_bufferable) begin
                ext_wbuf <= 1'b1;
              end else begin
                ext_req <= 1'b1;
              end
            end
          end else if (acc_req) begin
            ext_req <= 1'b1; // Read miss goes external
            if (acc_cachable && PRESENT != 0) begin
              // Line fill starts at word 0 of the line
              ext_addr  <= {acc_addr[31:`SAC_INDEX_LSB], 5'h00};
              fill_addr <= acc_addr;
              fill_way  <= victim;
              fill_cnt  <= 3'h0;
              fill_busy <= 1'b1;
              vic_adv   <= 1'b1;
              state     <= ST_FILL;
            end else begin
              ext_addr <= acc_addr;
            end
          end
        end
        ST_FILL: begin
          if (fill_valid) begin
            fill_cnt <= fill_cnt + 3'h1;
            if (fill_cnt == WORDS - 1) begin
              fill_busy <= 1'b0;
              state     <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### dv/sac_cache_monitor.sv
// Checker of port timing and debug word layout for the four-way cache
`timescale 1ns/1ps
`include "sac_cache_map.vh"
module sac_cache_monitor #(
  parameter SIZE_LOG2 = 12,
  parameter PRESENT   = 1,
  parameter IS_DATA   = 1
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Core side
  input wire logic        acc_req,
  input wire logic        acc_write,
  input wire logic        acc_cachable,
  input wire logic        acc_hit,
  // External side
  input wire logic        ext_req,
  input wire logic [31:0] ext_addr,
  input wire logic        fill_valid,
  input wire logic        fill_busy,
  // Control and debug
  input wire logic        flush_all,
  input wire logic        dbg_req,
  input wire logic [2:0]  dbg_op,
  input wire logic        dbg_ack,
  input wire logic [31:0] dbg_rdata
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  localparam int IDX_M = SIZE_LOG2 - 3; // Top bit of the index field
  reg [2:0] fill_cnt;  // Words taken in the current fill
  reg       busy_d;    // Fill busy one cycle late
  reg       any_valid; // Some line may be valid; a whole flush clears it

  // Counts fill words and tracks whether any line could hit
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fill_cnt  <= 3'h0;
      busy_d    <= 1'b0;
      any_valid <= 1'b0;
    end else begin
      busy_d   <= fill_busy;
      fill_cnt <= !fill_busy ? 3'h0 : fill_cnt + {2'h0, fill_valid};
      // Tag writes are counted as valid: safe, never a false alarm
      if (flush_all) begin
        any_valid <= 1'b0;
      end else if ((busy_d && !fill_busy) || (dbg_req && dbg_op == `SAC_OP_TAG_WR)) begin
        any_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rd_take; acc_req && !acc_write && !fill_busy; endsequence
  sequence wr_take; acc_req && acc_write && !fill_busy; endsequence
  sequence dbg_take; dbg_req && !fill_busy; endsequence

  chk_hit_timing: assert property (acc_hit |-> $past(acc_req && !acc_write && !fill_busy))
    else $error("hit without a read taken one cycle before");
  chk_read_answer: assert property (rd_take |=> acc_hit != ext_req)
    else $error("read gave neither or both of hit and external");
  chk_write_noalloc: assert property (wr_take |=> !acc_hit && !fill_busy)
    else $error("store hit or started a fill");
  chk_fill_kind: assert property (rd_take ##1 ext_req |-> fill_busy == $past(acc_cachable))
    else $error("fill start does not follow cachable attribute");
  chk_fill_base: assert property (ext_req && fill_busy |-> ext_addr[4:0] == 5'h00)
    else $error("fill address not line aligned");
  chk_fill_end: assert property (fill_busy && fill_valid && fill_cnt == 3'h7 |=> !fill_busy)
    else $error("fill did not end after eight words");
  chk_fill_hold: assert property (fill_busy && !(fill_valid && fill_cnt == 3'h7) |=> fill_busy)
    else $error("fill ended before eight words");
  chk_dbg_answer: assert property (dbg_take |=> dbg_ack)
    else $error("debug request not acknowledged");
  chk_idx_zero: assert property ((dbg_take and dbg_op == `SAC_OP_IDX_RD) |=>
    dbg_rdata[29:IDX_M+1] == '0 && dbg_rdata[1:0] == 2'h0)
    else $error("index read shows unused bits set");
  chk_tag_zero: assert property ((dbg_take and dbg_op == `SAC_OP_TAG_RD) |=>
    dbg_rdata[IDX_M:5] == '0 && dbg_rdata[1:0] == 2'h0)
    else $error("tag read shows unused bits set");
  chk_hit_valid: assert property (acc_hit |-> any_valid)
    else $error("hit with no valid line since reset or flush");
endmodule

bind sac_cache sac_cache_monitor #(.SIZE_LOG2(SIZE_LOG2), .PRESENT(PRESENT), .IS_DATA(IS_DATA))
  i_mon (.clk, .nrst, .acc_req, .acc_write, .acc_cachable, .acc_hit, .ext_req, .ext_addr,
         .fill_valid, .fill_busy, .flush_all, .dbg_req, .dbg_op, .dbg_ack, .dbg_rdata);

// ### dv/sac_ext_mem.sv
// External memory model answering cache line fills
`timescale 1ns/1ps
module sac_ext_mem (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // From the cache
  input  wire        ext_req,
  input  wire        fill_busy,
  input  wire [31:0] ext_addr,
  input  wire        slow,       // Idle cycle between words
  // To the cache
  output reg         fill_valid,
  output reg  [31:0] fill_data
);
  reg [26:0] base; // Line address of the fill
  reg [3:0]  left; // Words still to send
  reg [2:0]  word; // Next word in the line
  reg        gap;  // Idle cycle pending

  // Eight words from word 0; data toggles between words so it is never stale
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fill_valid <= 1'b0;
      fill_data  <= 32'h00000000;
      base       <= 27'h0;
      left       <= 4'h0;
      word       <= 3'h0;
      gap        <= 1'b0;
    end else if (ext_req && fill_busy) begin
      base       <= ext_addr[31:5];
      left       <= 4'h8;
      word       <= 3'h0;
      gap        <= slow;
      fill_valid <= 1'b0;
      fill_data  <= ~fill_data;
    end else if (left != 4'h0 && !gap) begin
      fill_valid <= 1'b1;
      fill_data  <= {base, word, 2'b00} ^ 32'h5A5A5A5A;
      left       <= left - 4'h1;
      word       <= word + 3'h1;
      gap        <= slow;
    end else begin
      fill_valid <= 1'b0;
      fill_data  <= ~fill_data;
      gap        <= 1'b0;
    end
  end
endmodule

// ### dv/tb.sv
// Self-checking testbench for the four-way cache with debug index access
`timescale 1ns/1ps
`include "sac_cache_map.vh"
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  reg         clk, nrst, acc_req, acc_write, acc_cachable, acc_bufferable;
  reg         repl_mode, flush_all, flush_line, dbg_req, slow;
  reg  [1:0]  lock_base;
  reg  [2:0]  dbg_op;
  reg  [31:0] acc_addr, acc_wdata, dbg_wdata;
  wire        acc_hit, ext_req, ext_wbuf, fill_valid, fill_busy, dbg_ack;
  wire [31:0] acc_rdata, ext_addr, ext_wdata, fill_data, dbg_rdata;
  reg  [3:0]  snap;       // Hit, external, write buffer, busy
  reg  [31:0] o_rd, o_ea; // Captured read data and external address
  integer     bad_count, num_checks, k;

  sac_cache #(.SIZE_LOG2(12), .PRESENT(1), .IS_DATA(1)) i_dut (.clk, .nrst, .acc_req,
    .acc_write, .acc_addr, .acc_wdata, .acc_cachable, .acc_bufferable, .acc_hit, .acc_rdata,
    .ext_req, .ext_wbuf, .ext_addr, .ext_wdata, .fill_valid, .fill_data, .fill_busy,
    .repl_mode, .lock_base, .flush_all, .flush_line, .dbg_req, .dbg_op, .dbg_wdata,
    .dbg_ack, .dbg_rdata);
  sac_ext_mem i_mem (.clk, .nrst, .ext_req, .fill_busy, .ext_addr, .slow, .fill_valid,
    .fill_data);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Memory image the model serves
  function automatic [31:0] mem(input [31:0] a);
    mem = {a[31:2], 2'b00} ^ 32'h5A5A5A5A;
  endfunction

  task automatic chk32(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input [3:0] got, input [3:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t flags %b expected %b", $time, got, exp);
    end
  endtask

  // One core access; waits out any fill under a bound
  task automatic acc(input w, input [31:0] a, input [31:0] d, input c, input b);
    integer n;
    @(posedge clk);
    acc_req        <= 1'b1;
    acc_write      <= w;
    acc_addr       <= a;
    acc_wdata      <= d;
    acc_cachable   <= c;
    acc_bufferable <= b;
    @(posedge clk);
    acc_req <= 1'b0;
    #1;
    snap = {acc_hit, ext_req, ext_wbuf, fill_busy};
    o_rd = acc_rdata;
    o_ea = ext_addr;
    n = 0;
    while (fill_busy === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
  endtask

  // Cachable read with expected flags; hits must return memory data
  task automatic rd(input [31:0] a, input [3:0] e);
    acc(1'b0, a, 32'h00000000, 1'b1, 1'b0);
    chkf(snap, e);
    if (e[3]) chk32(o_rd, mem(a));
  endtask

  task automatic dbg(input [2:0] op, input [31:0] d);
    @(posedge clk);
    dbg_req   <= 1'b1;
    dbg_op    <= op;
    dbg_wdata <= d;
    @(posedge clk);
    dbg_req <= 1'b0;
    #1;
    chkf({dbg_ack, 3'b000}, 4'b1000);
    o_rd = dbg_rdata;
  endtask

  task automatic flush(input line, input [31:0] a);
    @(posedge clk);
    flush_all  <= !line;
    flush_line <= line;
    acc_addr   <= a;
    @(posedge clk);
    flush_all  <= 1'b0;
    flush_line <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Miss after reset fills the whole line, then every word hits
  task automatic s_fill;
    rd(32'h00001044, 4'b0101);
    chk32(o_ea, 32'h00001040);
    for (k = 0; k < 8; k = k + 1) rd(32'h00001040 | (k << 2), 4'b1000);
  endtask

  // Four lines of one set live side by side; one fill is slow
  task automatic s_ways;
    for (k = 2; k < 5; k = k + 1) begin
      slow <= k[0];
      rd((k << 12) | 32'h40, 4'b0101);
    end
    for (k = 1; k < 5; k = k + 1) rd((k << 12) | 32'h5C, 4'b1000);
  endtask

  // Lockdown keeps lower ways resident in both replacement modes
  task automatic s_lock;
    lock_base <= 2'h3;
    rd(32'h00005040, 4'b0101);
    for (k = 1; k < 4; k = k + 1) rd((k << 12) | 32'h40, 4'b1000);
    rd(32'h00004040, 4'b0101);
    repl_mode <= `SAC_REPL_RANDOM;
    lock_base <= 2'h2;
    for (k = 6; k < 8; k = k + 1) rd((k << 12) | 32'h40, 4'b0101);
    for (k = 1; k < 3; k = k + 1) rd((k << 12) | 32'h40, 4'b1000);
  endtask

  // Write-back, write-through and missing stores; dirty per half line
  task automatic s_write;
    acc(1'b1, 32'h00001054, 32'hCAFE0001, 1'b1, 1'b1);
    chkf(snap, 4'b0000);
    acc(1'b0, 32'h00001054, 32'h00000000, 1'b1, 1'b0);
    chk32(o_rd, 32'hCAFE0001);
    dbg(`SAC_OP_IDX_WR, 32'h00000040);
    dbg(`SAC_OP_TAG_RD, 32'h00000000);
    chk32(o_rd, 32'h00001018);
    acc(1'b1, 32'h00002048, 32'hCAFE0002, 1'b1, 1'b0);
    chkf(snap, 4'b0100);
    chk32(o_ea, 32'h00002048);
    chk32(ext_wdata, 32'hCAFE0002);
    dbg(`SAC_OP_IDX_WR, 32'h40000040);
    dbg(`SAC_OP_TAG_RD, 32'h00000000);
    chk32(o_rd, 32'h00002010);
    acc(1'b1, 32'h00009000, 32'hCAFE0003, 1'b1, 1'b1);
    chkf(snap, 4'b0010);
    acc(1'b0, 32'h0000A000, 32'h00000000, 1'b0, 1'b0);
    chkf(snap, 4'b0100);
  endtask

  // Direct index, tag and data access through the debug register
  task automatic s_debug;
    dbg(`SAC_OP_IDX_WR, 32'hFFFFFFFF);
    dbg(`SAC_OP_IDX_RD, 32'h00000000);
    chk32(o_rd, 32'hC00003FC);
    dbg(`SAC_OP_IDX_WR, 32'h800000AC);
    dbg(`SAC_OP_TAG_WR, 32'h0ABCD410);
    dbg(`SAC_OP_DAT_WR, 32'h12345678);
    dbg(`SAC_OP_IDX_WR, 32'h800000A0);
    dbg(`SAC_OP_TAG_RD, 32'h00000000);
    chk32(o_rd, 32'h0ABCD410);
    acc(1'b0, 32'h0ABCD4AC, 32'h00000000, 1'b1, 1'b0);
    chkf(snap, 4'b1000);
    chk32(o_rd, 32'h12345678);
  endtask

  // Whole flush drops locked lines; single-line flush drops one line
  task automatic s_flush;
    flush(1'b0, 32'h00000000);
    rd(32'h00001040, 4'b0101);
    rd(32'h00001040, 4'b1000);
    flush(1'b1, 32'h00001040);
    rd(32'h00001040, 4'b0101);
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    nrst           = 1'b0;
    acc_req        = 1'b0;
    acc_write      = 1'b0;
    acc_cachable   = 1'b0;
    acc_bufferable = 1'b0;
    acc_addr       = 32'h00000000;
    acc_wdata      = 32'h00000000;
    repl_mode      = `SAC_REPL_ROUND;
    lock_base      = 2'h0;
    flush_all      = 1'b0;
    flush_line     = 1'b0;
    dbg_req        = 1'b0;
    dbg_op         = 3'h0;
    dbg_wdata      = 32'h00000000;
    slow           = 1'b0;
    bad_count      = 0;
    num_checks     = 0;
    repeat (16) @(posedge clk);
    chkf({acc_hit, ext_req, dbg_ack, fill_busy}, 4'h0);
    nrst <= 1'b1;
    dbg(`SAC_OP_IDX_RD, 32'h00000000);
    chk32(o_rd, `SAC_DBG_RESET);
    s_fill;
    s_ways;
    s_lock;
    s_write;
    s_debug;
    s_flush;
    end_sim;
  end

  // Run needs well under a thousand cycles; a hang ends here
  initial begin
    repeat (4000) @(posedge clk);
    bad_count = bad_count + 1;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim;
  end
endmodule
